/* File: rtl/plc_defines.svh */
// Purpose: Constants for the status lamp and crossover control block
// Assumes: 50 MHz core clock
// Notes: Offsets are register indices on the management port
`ifndef PLC_DEFINES_SVH
`define PLC_DEFINES_SVH
// ----------------------------------------
// Offsets
// ----------------------------------------
`define PLC_LAMP_CTRL_OFS 5'h18
`define PLC_XCVR_CTRL_OFS 5'h19
// ----------------------------------------
// Lamp control fields
// ----------------------------------------
`define PLC_LAMP_RATE_HI 10
`define PLC_LAMP_RATE_LO 9
`define PLC_LAMP_POL_BIT 7
`define PLC_LAMP_DRIVE_BIT 4
`define PLC_LAMP_ONOFF_BIT 1
`define PLC_LAMP_WR_MASK 16'h07ff
`define PLC_LAMP_CTRL_RST 16'h0000
// ----------------------------------------
// Transceiver control fields
// ----------------------------------------
`define PLC_XC_AUTO_BIT 15
`define PLC_XC_FORCE_BIT 14
`define PLC_XC_PRX_BIT 13
`define PLC_XC_PTX_BIT 12
`define PLC_XC_LINK_BIT 11
`define PLC_XC_BYPASS_BIT 7
`define PLC_XC_RESV_BIT 6
`define PLC_XC_STYLE_BIT 5
// ----------------------------------------
// Timing
// ----------------------------------------
`define PLC_CLK_MHZ 50
`define PLC_MS_CYCLES (`PLC_CLK_MHZ * 1000)
`define PLC_BLINK_MS_0 9'h032
`define PLC_BLINK_MS_1 9'h064
`define PLC_BLINK_MS_2 9'h0c8
`define PLC_BLINK_MS_3 9'h1f4
`endif

/* File: rtl/plc_pkg.sv */
// Purpose: Types for the status lamp and crossover control block
// Assumes: Constants come from plc_defines.svh
// Notes: All state of the block except the reset synchronizer flops is one packed struct
package plc_pkg;
    // ----------------------------------------
    // Management port request
    // ----------------------------------------
    typedef struct packed {
        logic [4:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } plc_req_type;
    // ----------------------------------------
    // Line status from the transceiver core
    // ----------------------------------------
    typedef struct packed {
        logic [1:0] localPause;
        logic [1:0] partnerPause;
        logic hcdFullDuplex;
        logic link100Full;
        logic linkUp;
        logic activity;
        logic autoCrossDetect;
    } plc_line_type;
    // ----------------------------------------
    // Straps
    // ----------------------------------------
    typedef struct packed {
        logic lampPolarity;
        logic autoCrossover;
        logic lampStyle;
    } plc_strap_type;
    // ----------------------------------------
    // Block state
    // ----------------------------------------
    typedef struct packed {
        logic strapDone;
        logic [15:0] lampCtrl;
        logic autoX;
        logic forceX;
        logic bypass;
        logic resv6;
        logic style;
        logic pauseRx;
        logic pauseTx;
        logic link100;
        logic [15:0] cycCnt;
        logic [8:0] msCnt;
        logic actHeld;
        logic blinkPhase;
        logic lampOut;
        logic crossOut;
        logic [15:0] rdata;
    } plc_state_type;
endpackage

/* File: rtl/plc_lamp_mdix.sv */
// Purpose: Status lamp control, crossover control and pause status registers
// Assumes: Inputs synchronous to clock; straps stable at reset release
// Notes: Read data stands in the cycle after the read strobe
//
// What this block does
// - Lamp output active high when polarity bit 7 is 1, else active low.
// - Polarity bit loads from strap at reset; software writes override it.
// - Override select bit 4 drives stored on/off value onto the lamp.
// - Bit 1 is read-write, resets 0, holds the forced lamp level.
// - Bit 15 enables automatic crossover; default taken from a strap.
// - Forced-crossover bit 14 swaps transmit and receive pairs.
// - Read-only bit 13 reports resolved pause receive enable.
// - Read-only bit 12 reports resolved pause transmit enable.
// - Pause bits only set when negotiated technology is full duplex.
// - Read-only bit 11 is 1 while a 100 Mb/s full-duplex link is up.
// - Bit 7 bypasses lamp stretching; lamp follows internal status directly.
// - Blink interval 50, 100, 200 or 500 ms from field bits 10:9.
// - Strapped style: lamp on for link, or also blink on activity.
//
// The strobed register port was left to the implementer.
`timescale 1ns/1ps
`include "plc_defines.svh"
module plc_lamp_mdix #(
    parameter int unsigned MsCycles = `PLC_MS_CYCLES
) (
    input wire logic clock,
    input wire logic arst_n,
    input wire plc_pkg::plc_req_type req,
    input wire plc_pkg::plc_line_type line,
    input wire plc_pkg::plc_strap_type strap,
    output logic [15:0] regRdata,
    output logic statusLampOut,
    output logic crossoverActive
);
    // ----------------------------------------
    // Reset release
    // ----------------------------------------
    logic rstMeta_r;
    logic rstSync_r;
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            rstMeta_r <= 1'b0;
            rstSync_r <= 1'b0;
        end else begin
            rstMeta_r <= 1'b1;
            rstSync_r <= rstMeta_r;
        end
    end

    // ----------------------------------------
    // State
    // ----------------------------------------
    plc_pkg::plc_state_type st_r;
    plc_pkg::plc_state_type st_nxt;
    logic [8:0] blinkMs;
    logic periodEnd;
    logic lampOn;
    logic lampLevel;
    logic wrLamp;
    logic wrXcvr;

    always_comb begin
        st_nxt = st_r;
        wrLamp = req.wr && (req.addr == `PLC_LAMP_CTRL_OFS);
        wrXcvr = req.wr && (req.addr == `PLC_XCVR_CTRL_OFS);
        // Straps caught on the first cycle after release
        if (!st_r.strapDone) begin
            st_nxt.strapDone = 1'b1;
            st_nxt.lampCtrl[`PLC_LAMP_POL_BIT] = strap.lampPolarity;
            st_nxt.autoX = strap.autoCrossover;
            st_nxt.style = strap.lampStyle;
        end
        // Register writes
        if (wrLamp) begin
            st_nxt.lampCtrl = req.wdata & `PLC_LAMP_WR_MASK;
        end
        if (wrXcvr) begin
            st_nxt.autoX = req.wdata[`PLC_XC_AUTO_BIT];
            st_nxt.forceX = req.wdata[`PLC_XC_FORCE_BIT];
            st_nxt.bypass = req.wdata[`PLC_XC_BYPASS_BIT];
            st_nxt.resv6 = req.wdata[`PLC_XC_RESV_BIT];
            st_nxt.style = req.wdata[`PLC_XC_STYLE_BIT];
        end
        // Pause resolution, full duplex only
        st_nxt.pauseTx = 1'b0;
        st_nxt.pauseRx = 1'b0;
        if (line.hcdFullDuplex) begin
            if (line.localPause[0] && line.partnerPause[0]) begin
                st_nxt.pauseTx = 1'b1;
                st_nxt.pauseRx = 1'b1;
            end else if (line.localPause == 2'h2 && line.partnerPause == 2'h3) begin
                st_nxt.pauseTx = 1'b1;
            end else if (line.localPause == 2'h3 && line.partnerPause == 2'h2) begin
                st_nxt.pauseRx = 1'b1;
            end
        end
        st_nxt.link100 = line.link100Full;
        // Blink interval timer
        unique case (st_r.lampCtrl[`PLC_LAMP_RATE_HI:`PLC_LAMP_RATE_LO])
            2'h0: blinkMs = `PLC_BLINK_MS_0;
            2'h1: blinkMs = `PLC_BLINK_MS_1;
            2'h2: blinkMs = `PLC_BLINK_MS_2;
            2'h3: blinkMs = `PLC_BLINK_MS_3;
        endcase
        periodEnd = 1'b0;
        if (st_r.cycCnt >= 16'(MsCycles - 1)) begin
            st_nxt.cycCnt = 16'h0000;
            if (st_r.msCnt >= blinkMs - 9'h001) begin
                st_nxt.msCnt = 9'h000;
                periodEnd = 1'b1;
            end else begin
                st_nxt.msCnt = st_r.msCnt + 9'h001;
            end
        end else begin
            st_nxt.cycCnt = st_r.cycCnt + 16'h0001;
        end
        // Activity stretching: one on/off phase per interval
        if (periodEnd) begin
            st_nxt.blinkPhase = st_r.actHeld ? ~st_r.blinkPhase : 1'b0;
            st_nxt.actHeld = line.activity;
        end else if (line.activity) begin
            st_nxt.actHeld = 1'b1;
        end
        // Lamp value
        if (st_r.bypass) begin
            lampOn = line.linkUp && (st_r.style || !line.activity);
        end else begin
            lampOn = line.linkUp && (st_r.style || !st_r.blinkPhase);
        end
        if (st_r.lampCtrl[`PLC_LAMP_DRIVE_BIT]) begin
            lampLevel = st_r.lampCtrl[`PLC_LAMP_ONOFF_BIT];
        end else begin
            lampLevel = lampOn;
        end
        st_nxt.lampOut = st_r.lampCtrl[`PLC_LAMP_POL_BIT] ? lampLevel : ~lampLevel;
        st_nxt.crossOut = st_r.forceX || (st_r.autoX && line.autoCrossDetect);
        // Read data
        st_nxt.rdata = 16'h0000;
        if (req.rd && req.addr == `PLC_LAMP_CTRL_OFS) begin
            st_nxt.rdata = st_r.lampCtrl;
        end else if (req.rd && req.addr == `PLC_XCVR_CTRL_OFS) begin
            st_nxt.rdata[`PLC_XC_AUTO_BIT] = st_r.autoX;
            st_nxt.rdata[`PLC_XC_FORCE_BIT] = st_r.forceX;
            st_nxt.rdata[`PLC_XC_PRX_BIT] = st_r.pauseRx;
            st_nxt.rdata[`PLC_XC_PTX_BIT] = st_r.pauseTx;
            st_nxt.rdata[`PLC_XC_LINK_BIT] = st_r.link100;
            st_nxt.rdata[`PLC_XC_BYPASS_BIT] = st_r.bypass;
            st_nxt.rdata[`PLC_XC_RESV_BIT] = st_r.resv6;
            st_nxt.rdata[`PLC_XC_STYLE_BIT] = st_r.style;
        end
    end

    always_ff @(posedge clock or negedge rstSync_r) begin
        if (!rstSync_r) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign regRdata = st_r.rdata;
    assign statusLampOut = st_r.lampOut;
    assign crossoverActive = st_r.crossOut;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstSync_r);

    sequence s_lampWrite;
        req.wr && req.addr == `PLC_LAMP_CTRL_OFS;
    endsequence
    sequence s_forceHeld;
        st_r.lampCtrl[`PLC_LAMP_DRIVE_BIT] [*2];
    endsequence
    sequence s_lampRead;
        req.rd && req.addr == `PLC_LAMP_CTRL_OFS;
    endsequence
    sequence s_xcvrRead;
        req.rd && req.addr == `PLC_XCVR_CTRL_OFS;
    endsequence

    property p_polarity;
        st_r.strapDone && !st_r.lampCtrl[`PLC_LAMP_DRIVE_BIT] && !st_r.bypass
            |=> statusLampOut == ($past(st_r.lampCtrl[`PLC_LAMP_POL_BIT]) ~^
                $past(line.linkUp && (st_r.style || !st_r.blinkPhase)));
    endproperty
    a_polarity: assert property (p_polarity) else $error("lamp polarity wrong");

    property p_strap;
        $rose(st_r.strapDone) |-> st_r.lampCtrl[`PLC_LAMP_POL_BIT] == $past(strap.lampPolarity)
            && st_r.autoX == $past(strap.autoCrossover);
    endproperty
    a_strap: assert property (p_strap) else $error("strap not loaded");

    property p_force;
        s_lampWrite ##1 s_forceHeld |-> statusLampOut == ($past(st_r.lampCtrl[`PLC_LAMP_POL_BIT]) ~^
            $past(st_r.lampCtrl[`PLC_LAMP_ONOFF_BIT]));
    endproperty
    a_force: assert property (p_force) else $error("forced lamp level wrong");

    property p_onoffWrite;
        s_lampWrite |=> st_r.lampCtrl[`PLC_LAMP_ONOFF_BIT] ==
            $past(req.wdata[`PLC_LAMP_ONOFF_BIT]);
    endproperty
    a_onoffWrite: assert property (p_onoffWrite) else $error("on/off bit not held");

    property p_lampRead;
        s_lampRead |=> regRdata == $past(st_r.lampCtrl);
    endproperty
    a_lampRead: assert property (p_lampRead) else $error("lamp register read wrong");

    property p_bypass;
        st_r.strapDone && !st_r.lampCtrl[`PLC_LAMP_DRIVE_BIT] && st_r.bypass
            |=> statusLampOut == ($past(st_r.lampCtrl[`PLC_LAMP_POL_BIT]) ~^
                $past(line.linkUp && (st_r.style || !line.activity)));
    endproperty
    a_bypass: assert property (p_bypass) else $error("bypassed lamp wrong");

    property p_autoOn;
        st_r.autoX && line.autoCrossDetect |=> crossoverActive;
    endproperty
    a_autoOn: assert property (p_autoOn) else $error("auto crossover missed");

    property p_autoOff;
        !st_r.autoX && !st_r.forceX |=> !crossoverActive;
    endproperty
    a_autoOff: assert property (p_autoOff) else $error("crossover without cause");

    property p_cross;
        st_r.forceX |=> crossoverActive;
    endproperty
    a_cross: assert property (p_cross) else $error("forced crossover lost");

    property p_pauseHalf;
        !line.hcdFullDuplex |=> !st_r.pauseRx && !st_r.pauseTx;
    endproperty
    a_pauseHalf: assert property (p_pauseHalf) else $error("pause set in half duplex");

    property p_pauseBoth;
        line.hcdFullDuplex && line.localPause[0] && line.partnerPause[0]
            |=> st_r.pauseRx && st_r.pauseTx;
    endproperty
    a_pauseBoth: assert property (p_pauseBoth) else $error("symmetric pause missed");

    property p_pauseTxOnly;
        line.hcdFullDuplex && line.localPause == 2'h2 && line.partnerPause == 2'h3
            |=> st_r.pauseTx && !st_r.pauseRx;
    endproperty
    a_pauseTxOnly: assert property (p_pauseTxOnly) else $error("transmit pause wrong");

    property p_link100;
        line.link100Full |=> st_r.link100;
    endproperty
    a_link100: assert property (p_link100) else $error("link bit not reported");

    property p_statusRead;
        s_xcvrRead |=> regRdata[`PLC_XC_LINK_BIT] == $past(st_r.link100)
            && regRdata[`PLC_XC_PRX_BIT] == $past(st_r.pauseRx)
            && regRdata[`PLC_XC_PTX_BIT] == $past(st_r.pauseTx);
    endproperty
    a_statusRead: assert property (p_statusRead) else $error("status bits read wrong");
endmodule

/* File: verif/plc_line_model.sv */
// Purpose: Far-side model of the transceiver core line status
// Assumes: Bench sets the wanted status on cmd
// Notes: Status follows cmd one clock later, like the core's own flops
`timescale 1ns/1ps
module plc_line_model (
    input wire logic clock,
    input wire plc_pkg::plc_line_type cmd,
    output plc_pkg::plc_line_type line
);
    initial line = '0;
    // Registered status, no glitches between edges
    always @(posedge clock) begin
        line <= cmd;
    end
endmodule

/* File: verif/plc_lamp_mdix_tb.sv */
// Purpose: Self-checking bench for the lamp and crossover registers
// Assumes: All straps tied high; MsCycles shortened to 4
// Notes: Reads queue their expected data; a monitor compares them
`timescale 1ns/1ps
`include "plc_defines.svh"
module plc_lamp_mdix_tb;
    logic clock;
    logic arst_n;
    plc_pkg::plc_req_type req;
    plc_pkg::plc_line_type cmd;
    plc_pkg::plc_line_type line;
    plc_pkg::plc_strap_type strap;
    logic [15:0] regRdata;
    logic statusLampOut;
    logic crossoverActive;
    logic [15:0] expQ[$];
    logic rdPend = 1'b0;
    logic [31:0] lfsr = 32'hfa52;
    logic [1:0] lp;
    logic [1:0] pp;
    logic tx;
    logic rx;
    logic prevLamp;
    int miscompares = 0;
    int checked = 0;
    int cycles = 0;
    plc_line_model i_plc_line_model (.clock(clock), .cmd(cmd), .line(line));
    plc_lamp_mdix #(.MsCycles(4)) i_plc_lamp_mdix (.clock(clock), .arst_n(arst_n),
        .req(req), .line(line), .strap(strap), .regRdata(regRdata),
        .statusLampOut(statusLampOut), .crossoverActive(crossoverActive));
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [31:0] nextRand(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task automatic compare(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: read %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chkBit(input logic got, input logic exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: pin %b expected %b", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        req.addr <= a;
        req.wdata <= d;
        req.wr <= 1'b1;
        cyc(1);
        req.wr <= 1'b0;
        cyc(1);
    endtask
    task automatic rd(input logic [4:0] a, input logic [15:0] e);
        expQ.push_back(e);
        req.addr <= a;
        req.rd <= 1'b1;
        cyc(1);
        req.rd <= 1'b0;
        cyc(1);
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // ----------------------------------------
    // Clock, monitor and timeout
    // ----------------------------------------
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    always @(posedge clock) begin
        if (rdPend && expQ.size() > 0) begin
            compare(regRdata, expQ.pop_front());
        end
        rdPend <= req.rd;
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            miscompares++;
            conclude();
        end
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        arst_n = 1'b0;
        req = '0;
        cmd = '0;
        strap = 3'b111;
        cyc(6);
        arst_n <= 1'b1;
        cyc(6);
        rd(`PLC_LAMP_CTRL_OFS, 16'h0080);
        rd(`PLC_XCVR_CTRL_OFS, 16'h8020);
        $display("reset values done");
        // Polarity, link lamp, forced level
        for (int i = 0; i < 5; i++) begin
            cmd.linkUp <= (i > 1);
            wr(`PLC_LAMP_CTRL_OFS, i == 0 ? 16'h0 : (i < 3 ? 16'h0080 : 16'h0090 | 16'(i & 2)));
            cyc(2);
            chkBit(statusLampOut, 1'(5'b01101 >> i));
        end
        $display("lamp drive done");
        for (int i = 0; i < 8; i++) begin
            lfsr = nextRand(lfsr);
            wr(`PLC_LAMP_CTRL_OFS, lfsr[15:0]);
            rd(`PLC_LAMP_CTRL_OFS, lfsr[15:0] & `PLC_LAMP_WR_MASK);
        end
        wr(5'h1a, 16'hffff);
        rd(5'h1a, 16'h0000);
        $display("lamp register done");
        wr(`PLC_XCVR_CTRL_OFS, 16'hffff);
        rd(`PLC_XCVR_CTRL_OFS, 16'hc0e0);
        chkBit(crossoverActive, 1'b1);
        for (int i = 0; i < 4; i++) begin
            cmd.autoCrossDetect <= i[0];
            wr(`PLC_XCVR_CTRL_OFS, i[1] ? 16'h8020 : 16'h0020);
            cyc(2);
            chkBit(crossoverActive, i[1] & i[0]);
        end
        $display("crossover done");
        for (int i = 0; i < 32; i++) begin
            lp = i[1:0];
            pp = i[3:2];
            tx = i[4] & ((lp[0] & pp[0]) | (lp == 2'b10 && pp == 2'b11));
            rx = i[4] & ((lp[0] & pp[0]) | (lp == 2'b11 && pp == 2'b10));
            cmd.localPause <= lp;
            cmd.partnerPause <= pp;
            cmd.hcdFullDuplex <= i[4];
            cmd.link100Full <= i[0];
            cyc(3);
            rd(`PLC_XCVR_CTRL_OFS, {2'b10, rx, tx, i[0], 11'h020});
        end
        $display("pause status done");
        // Bypass and activity blink, style 0
        cmd.activity <= 1'b1;
        wr(`PLC_LAMP_CTRL_OFS, 16'h0280);
        wr(`PLC_XCVR_CTRL_OFS, 16'h0080);
        cyc(2);
        chkBit(statusLampOut, 1'b0);
        cmd.activity <= 1'b0;
        cyc(3);
        chkBit(statusLampOut, 1'b1);
        cmd.activity <= 1'b1;
        wr(`PLC_XCVR_CTRL_OFS, 16'h0000);
        cyc(400);
        prevLamp = statusLampOut;
        cyc(400);
        chkBit(statusLampOut, ~prevLamp);
        cyc(400);
        chkBit(statusLampOut, prevLamp);
        cmd.activity <= 1'b0;
        cyc(850);
        chkBit(statusLampOut, 1'b1);
        $display("blink done");
        cyc(2);
        conclude();
    end
endmodule
